// file: inc/mfr_regs.svh
// Purpose: Shared constants of the multi-line fast read front end.
// Assumes: Included by the package and by both link ends.
// Notes:   Offsets are byte addresses on the host's register bus.
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// Instruction codes
`define MFR_OP_QUAD_OUT 8'h6B
`define MFR_OP_DUAL_IO 8'hBB
`define MFR_OP_QUAD_IO 8'hEB
`define MFR_OP_WORD_QIO 8'hE7
`define MFR_OP_OCT_QIO 8'hE3

// Frame geometry in serial clocks and bits
`define MFR_INS_CLKS 6'h08
`define MFR_ADDR_BITS 24
`define MFR_MODE_BITS 8
`define MFR_DUM_QUAD_OUT 6'h08
`define MFR_DUM_QUAD_IO 6'h04
`define MFR_DUM_WORD_QIO 6'h02
`define MFR_DUM_NONE 6'h00
`define MFR_CONT_NIBBLE 4'hA

// Idle pin levels {cs_n, sck, io[3:0]}
`define MFR_PIN_IDLE 6'h2F

// Host serial clock half period in system clocks
`define MFR_SCK_HALF 12

// Host register offsets
`define MFR_REG_CTRL 8'h00
`define MFR_REG_ADDR 8'h04
`define MFR_REG_MODE 8'h08
`define MFR_REG_STAT 8'h0C
`define MFR_REG_RDATA 8'h10

// Control fields
`define MFR_CTRL_SEL_LSB 0
`define MFR_CTRL_LEN_LSB 4
`define MFR_CTRL_QUAD_EN_BIT 8
`define MFR_CTRL_GO_BIT 9

// Status fields
`define MFR_STAT_BUSY_BIT 0
`define MFR_STAT_DONE_BIT 1
`define MFR_STAT_CONT_BIT 2
`define MFR_STAT_REFUSED_BIT 3

`endif

// file: inc/mfr_pkg.sv
// Purpose: Types and frame arithmetic shared by both link ends.
// Assumes: mfr_regs.svh is on the include path.
// Notes:   Clock index k counts rising serial clock edges in a frame up to the data phase, then holds.
`include "mfr_regs.svh"
package mfr_pkg;

	typedef enum logic [2:0] {MFR_CMD_NONE, MFR_CMD_QUAD_OUT, MFR_CMD_DUAL_IO, MFR_CMD_QUAD_IO,
		MFR_CMD_WORD_QIO, MFR_CMD_OCT_QIO} mfr_cmd_e;
	typedef enum logic [2:0] {MFR_PH_INS, MFR_PH_ADDR, MFR_PH_MODE, MFR_PH_DUMMY, MFR_PH_DATA} mfr_phase_e;
	typedef logic [5:0] mfr_clk_t;

	// Opcode to read kind
	function automatic mfr_cmd_e mfr_decode(logic [7:0] op);
		case (op)
			`MFR_OP_QUAD_OUT: return MFR_CMD_QUAD_OUT;
			`MFR_OP_DUAL_IO: return MFR_CMD_DUAL_IO;
			`MFR_OP_QUAD_IO: return MFR_CMD_QUAD_IO;
			`MFR_OP_WORD_QIO: return MFR_CMD_WORD_QIO;
			`MFR_OP_OCT_QIO: return MFR_CMD_OCT_QIO;
			default: return MFR_CMD_NONE;
		endcase
	endfunction

	// Read kind to opcode
	function automatic logic [7:0] mfr_opcode(mfr_cmd_e c);
		case (c)
			MFR_CMD_QUAD_OUT: return `MFR_OP_QUAD_OUT;
			MFR_CMD_DUAL_IO: return `MFR_OP_DUAL_IO;
			MFR_CMD_QUAD_IO: return `MFR_OP_QUAD_IO;
			MFR_CMD_WORD_QIO: return `MFR_OP_WORD_QIO;
			default: return `MFR_OP_OCT_QIO;
		endcase
	endfunction

	// Lines used for address and mode, and for data
	function automatic logic [2:0] mfr_lines_addr(mfr_cmd_e c);
		return (c == MFR_CMD_QUAD_OUT) ? 3'h1 : (c == MFR_CMD_DUAL_IO) ? 3'h2 : 3'h4;
	endfunction

	function automatic logic [2:0] mfr_lines_data(mfr_cmd_e c);
		return (c == MFR_CMD_DUAL_IO) ? 3'h2 : 3'h4;
	endfunction

	function automatic logic mfr_has_mode(mfr_cmd_e c);
		return (c != MFR_CMD_QUAD_OUT) && (c != MFR_CMD_NONE);
	endfunction

	function automatic logic mfr_needs_quad_en(mfr_cmd_e c);
		return (c != MFR_CMD_DUAL_IO) && (c != MFR_CMD_NONE);
	endfunction

	// Dummy clocks ahead of data
	function automatic mfr_clk_t mfr_dummy(mfr_cmd_e c);
		case (c)
			MFR_CMD_QUAD_OUT: return `MFR_DUM_QUAD_OUT;
			MFR_CMD_QUAD_IO: return `MFR_DUM_QUAD_IO;
			MFR_CMD_WORD_QIO: return `MFR_DUM_WORD_QIO;
			default: return `MFR_DUM_NONE;
		endcase
	endfunction

	// Phase of serial clock k within a frame
	function automatic mfr_phase_e mfr_phase(mfr_cmd_e c, logic skip, mfr_clk_t k);
		mfr_clk_t ins, a, m, d;
		ins = skip ? 6'h00 : `MFR_INS_CLKS;
		a = ins + 6'(`MFR_ADDR_BITS / int'(mfr_lines_addr(c)));
		m = a + (mfr_has_mode(c) ? 6'(`MFR_MODE_BITS / int'(mfr_lines_addr(c))) : 6'h00);
		d = m + mfr_dummy(c);
		if (k < ins) return MFR_PH_INS;
		if (k < a) return MFR_PH_ADDR;
		if (k < m) return MFR_PH_MODE;
		if (k < d) return MFR_PH_DUMMY;
		return MFR_PH_DATA;
	endfunction

	// Bits taken from the lines, highest line most significant
	function automatic logic [3:0] mfr_take(logic [3:0] io, logic [2:0] lines);
		return (lines == 3'h1) ? {3'h0, io[0]} : (lines == 3'h2) ? {2'h0, io[1:0]} : io;
	endfunction

	// Top bits of a byte placed on the lines, highest line most significant
	function automatic logic [3:0] mfr_put(logic [7:0] v, logic [2:0] lines);
		return (lines == 3'h1) ? {3'h0, v[7]} : (lines == 3'h2) ? {2'h0, v[7:6]} : v[7:4];
	endfunction

	function automatic logic [3:0] mfr_oe(logic [2:0] lines);
		return (lines == 3'h1) ? 4'h1 : (lines == 3'h2) ? 4'h3 : 4'hF;
	endfunction

endpackage

// file: inc/mfr_link_if.sv
// Purpose: Serial flash link between host controller and flash device.
// Assumes: Each end gives output and enable per IO line.
// Notes:   Undriven lines read high, as with a pull-up.
`timescale 1ns/1ps
interface mfr_link_if;
	logic sck;
	logic cs_n;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	logic [3:0] io;

	// Resolved line level, device first, then host, else pulled high
	assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

	modport host (output sck, output cs_n, output h_io_o, output h_io_oe, input io);
	modport dev (input sck, input cs_n, input io, output d_io_o, output d_io_oe);
endinterface

// file: src/mfr_host.sv
// Purpose: Host controller issuing multi-line fast reads from register orders.
// Assumes: Classic Wishbone slave on SYS_CLK; device answers within half a serial clock.
// Notes:   Serial clock is SYS_CLK divided by 2*HALF, idle low.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_host #(
	parameter int HALF = `MFR_SCK_HALF
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	// Flash link
	mfr_link_if.host LINK
);
	import mfr_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_LOAD, H_RUN, H_TAIL} mfr_hst_e;

	logic ack_q, acc, wr, go, legal, start, tick, drv_now;
	logic [31:0] dat_q, ctrl_rd, ctrl_new;
	logic [7:0] adr;
	mfr_cmd_e sel_q, nsel, run_q, hcont_q;
	logic [1:0] len_q;
	logic quad_en_q, done_q, refused_q, skip_q, sck_q, cs_q;
	logic [23:0] addr_r_q;
	logic [7:0] mode_r_q, hcnt_q;
	mfr_hst_e st_q;
	mfr_clk_t k_q;
	logic [4:0] dk_q, dk_end_q;
	logic [3:0] io_o_q, io_oe_q, s1_q, s2_q, s3_q, filt_q;
	logic [39:0] sh_q;
	logic [31:0] rx_q, rdata_q;
	mfr_phase_e ph;
	logic [2:0] la, ld, dl, nbytes;

	// Byte-enable merge of a register write
	function automatic logic [31:0] wmask(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (nw & m) | (old & ~m);
	endfunction

	// Drive phases carry host bits
	function automatic logic drives(mfr_phase_e p);
		return (p == MFR_PH_INS) || (p == MFR_PH_ADDR) || (p == MFR_PH_MODE);
	endfunction

	// Bus decode and order checks
	assign adr = {WB_ADR_I[7:2], 2'h0};
	assign acc = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wr = acc & WB_WE_I;
	assign ctrl_rd = {22'h00_0000, 1'b0, quad_en_q, 2'h0, len_q, 1'b0, sel_q};
	assign ctrl_new = wmask(ctrl_rd, WB_DAT_I, WB_SEL_I);
	assign nsel = mfr_cmd_e'(ctrl_new[`MFR_CTRL_SEL_LSB +: 3]);
	assign go = wr & (adr == `MFR_REG_CTRL) & ctrl_new[`MFR_CTRL_GO_BIT] & (st_q == H_IDLE);
	// Quad kinds need the enable; another kind must wait until continuous mode is left
	assign legal = (nsel != MFR_CMD_NONE) && nsel <= MFR_CMD_OCT_QIO
		&& (!mfr_needs_quad_en(nsel) || ctrl_new[`MFR_CTRL_QUAD_EN_BIT])
		&& (hcont_q == MFR_CMD_NONE || hcont_q == nsel);
	assign start = go & legal;

	// Frame arithmetic
	assign ph = mfr_phase(run_q, skip_q, k_q);
	// Bytes asked for, one to four; wide enough that four does not wrap
	assign nbytes = {1'b0, ctrl_new[`MFR_CTRL_LEN_LSB +: 2]} + 3'h1;
	assign la = mfr_lines_addr(run_q);
	assign ld = mfr_lines_data(run_q);
	assign dl = (ph == MFR_PH_INS) ? 3'h1 : la;
	assign tick = (hcnt_q == 8'(HALF - 1));
	assign drv_now = (st_q == H_LOAD) | ((st_q == H_RUN) & tick & sck_q & drives(ph));

	// Wishbone answer, one cycle after the request
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			if (acc & ~WB_WE_I) begin
				unique case (adr)
					`MFR_REG_CTRL: dat_q <= ctrl_rd;
					`MFR_REG_ADDR: dat_q <= {8'h00, addr_r_q};
					`MFR_REG_MODE: dat_q <= {24'h00_0000, mode_r_q};
					`MFR_REG_STAT: dat_q <= {28'h000_0000, refused_q, hcont_q != MFR_CMD_NONE, done_q, st_q != H_IDLE};
					`MFR_REG_RDATA: dat_q <= rdata_q;
					default: dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Order registers
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_q <= MFR_CMD_NONE;
			len_q <= 2'h0;
			quad_en_q <= 1'b0;
			addr_r_q <= 24'h00_0000;
			mode_r_q <= 8'h00;
		end else if (wr) begin
			if (adr == `MFR_REG_CTRL) begin
				sel_q <= nsel;
				len_q <= ctrl_new[`MFR_CTRL_LEN_LSB +: 2];
				quad_en_q <= ctrl_new[`MFR_CTRL_QUAD_EN_BIT];
			end
			if (adr == `MFR_REG_ADDR)
				addr_r_q <= 24'(wmask({8'h00, addr_r_q}, WB_DAT_I, WB_SEL_I));
			if (adr == `MFR_REG_MODE)
				mode_r_q <= 8'(wmask({24'h00_0000, mode_r_q}, WB_DAT_I, WB_SEL_I));
		end
	end

	// Status flags, the end of a frame wins over a start in the same cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_q <= 1'b0;
			refused_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (start) begin
				done_q <= 1'b0;
				refused_q <= 1'b0;
			end else if (go)
				refused_q <= 1'b1;
			if (st_q == H_TAIL && tick) begin
				done_q <= 1'b1;
				rdata_q <= rx_q;
			end
		end
	end

	// Continuous mode mirror of the device
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			hcont_q <= MFR_CMD_NONE;
		else if (start && mfr_has_mode(nsel))
			hcont_q <= (mode_r_q[7:4] == `MFR_CONT_NIBBLE) ? nsel : MFR_CMD_NONE;
	end

	// Three-flop input sync with agreement filter
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= 4'hF;
			s2_q <= 4'hF;
			s3_q <= 4'hF;
			filt_q <= 4'hF;
		end else begin
			s1_q <= LINK.io;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
		end
	end

	// Frame sequencer and serial clock divider
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= H_IDLE;
			hcnt_q <= 8'h00;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			run_q <= MFR_CMD_NONE;
			skip_q <= 1'b0;
			k_q <= 6'h00;
			dk_q <= 5'h00;
			dk_end_q <= 5'h00;
			rx_q <= 32'h0000_0000;
		end else begin
			hcnt_q <= (st_q == H_IDLE || st_q == H_LOAD || tick) ? 8'h00 : hcnt_q + 8'h01;
			unique case (st_q)
				H_IDLE: if (start) begin
					run_q <= nsel;
					skip_q <= (hcont_q == nsel);
					k_q <= 6'h00;
					dk_q <= 5'h00;
					// Data clocks: four per byte on two lines, two per byte on four
					dk_end_q <= (nsel == MFR_CMD_DUAL_IO) ? {nbytes, 2'h0} : {1'b0, nbytes, 1'b0};
					cs_q <= 1'b0;
					st_q <= H_LOAD;
				end
				H_LOAD: st_q <= H_RUN;
				H_RUN: if (tick && !sck_q) begin
					sck_q <= 1'b1;
					if (ph == MFR_PH_DATA) begin
						dk_q <= dk_q + 5'h01;
						rx_q <= (rx_q << ld) | {28'h000_0000, mfr_take(filt_q, ld)};
					end else
						k_q <= k_q + 6'h01;
				end else if (tick) begin
					sck_q <= 1'b0;
					if (ph == MFR_PH_DATA && dk_q == dk_end_q)
						st_q <= H_TAIL;
				end
				H_TAIL: if (tick) begin
					cs_q <= 1'b1;
					st_q <= H_IDLE;
				end
			endcase
		end
	end

	// Host line drivers: bits change while the clock is low
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sh_q <= 40'h00_0000_0000;
			io_o_q <= 4'hF;
			io_oe_q <= 4'h0;
		end else if (st_q == H_IDLE && start) begin
			// Aligned reads force their low address bits to zero
			sh_q <= (hcont_q == nsel) ?
				{(nsel == MFR_CMD_OCT_QIO) ? {addr_r_q[23:4], 4'h0} :
				(nsel == MFR_CMD_WORD_QIO) ? {addr_r_q[23:1], 1'b0} : addr_r_q, mode_r_q, 8'h00} :
				{mfr_opcode(nsel), (nsel == MFR_CMD_OCT_QIO) ? {addr_r_q[23:4], 4'h0} :
				(nsel == MFR_CMD_WORD_QIO) ? {addr_r_q[23:1], 1'b0} : addr_r_q, mode_r_q};
		end else if (drv_now) begin
			io_o_q <= mfr_put(sh_q[39:32], dl);
			io_oe_q <= mfr_oe(dl);
			sh_q <= sh_q << dl;
		end else if (st_q == H_RUN && tick && sck_q && !drives(ph))
			// Let go at the fall after the last driven bit; at the rise the bit would be lost
			io_oe_q <= 4'h0;
		else if (st_q == H_TAIL)
			io_oe_q <= 4'h0;
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign LINK.sck = sck_q;
	assign LINK.cs_n = cs_q;
	assign LINK.h_io_o = io_o_q;
	assign LINK.h_io_oe = io_oe_q;
endmodule // mfr_host

// file: src/mfr_flash_dev.sv
// Purpose: Flash device front end for the multi-line fast reads.
// Assumes: Link pins come from another domain; array and status inputs share SYS_CLK.
// Notes:   Serial clock must stay low or high for at least five SYS_CLK cycles.
// What this block does
// - Quad output read returns data on four lines
// - Quad output read needs quad enable set
// - Eight ignored dummy clocks follow quad output address
// - Host releases lines by the first data fall
// - Dual read moves address and data two-wide
// - Mode byte follows address; lower nibble ignored
// - Dual mode nibble A skips next instruction
// - Other nibble leaves continuous mode
// - Quad read uses four lines, four dummies
// - Quad address reads need quad enable
// - Quad mode nibble A skips next instruction
// - Word read: address bit zero clear, two dummies
// - Word read nibble A skips next instruction
// - Sixteen-byte read: low nibble clear, no dummies
// - Sixteen-byte read nibble A skips instruction
// - Host may reset continuous mode first
// - Instruction and address sampled on rising clock
// - Data shifted out on falling clock, MSB first
// - Address advances per byte until deselect
// - Reads ignored while a write cycle runs
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_flash_dev (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Flash link
	mfr_link_if.dev LINK,
	// Array status
	input wire logic QUAD_LINES_ENABLE_BIT,
	input wire logic WRITE_CYCLE_BUSY,
	// Array read port
	output logic [23:0] MEM_ADDR,
	input wire logic [7:0] MEM_RDATA,
	// Continuous read state
	output mfr_pkg::mfr_cmd_e CONT_CMD
);
	import mfr_pkg::*;

	logic [5:0] s1_q, s2_q, s3_q, filt_q;
	logic sck_prev_q, cs_prev_q;
	logic rise, fall, cs_hi, start, act;
	mfr_cmd_e cmd_q, cont_q, op_cmd;
	logic skip_q, ign_q;
	mfr_clk_t k_q;
	mfr_phase_e ph, ph_next;
	logic [6:0] ins_q;
	logic [7:0] mode_q, mode_nx, sh_q;
	logic [23:0] addr_q;
	logic [1:0] dcnt_q;
	logic [3:0] io_o_q, io_oe_q, bits;
	logic [2:0] la, ld;
	logic byte_start, last_bit;

	// Refusal of a read kind given the array state
	function automatic logic refuse(mfr_cmd_e c, logic busy, logic quad_en);
		return (c == MFR_CMD_NONE) || busy || (mfr_needs_quad_en(c) && !quad_en);
	endfunction

	// Three-flop sync of {cs_n, sck, io}; a change counts when flops two and three agree
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= `MFR_PIN_IDLE;
			s2_q <= `MFR_PIN_IDLE;
			s3_q <= `MFR_PIN_IDLE;
			filt_q <= `MFR_PIN_IDLE;
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			s1_q <= {LINK.cs_n, LINK.sck, LINK.io};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
			sck_prev_q <= filt_q[4];
			cs_prev_q <= filt_q[5];
		end
	end

	// Edge and frame events
	assign rise = filt_q[4] & ~sck_prev_q;
	assign fall = ~filt_q[4] & sck_prev_q;
	assign cs_hi = filt_q[5];
	assign start = ~filt_q[5] & cs_prev_q;
	assign act = ~cs_hi & ~ign_q;

	// Frame arithmetic for the current read kind
	assign ph = mfr_phase(cmd_q, skip_q, k_q);
	assign ph_next = mfr_phase(cmd_q, skip_q, k_q + 6'h01);
	assign la = mfr_lines_addr(cmd_q);
	assign ld = mfr_lines_data(cmd_q);
	assign bits = mfr_take(filt_q[3:0], la);
	assign op_cmd = mfr_decode({ins_q, filt_q[0]});
	assign mode_nx = (mode_q << la) | {4'h0, bits};
	assign byte_start = fall & act & (ph == MFR_PH_DATA) & (dcnt_q == 2'h0);
	assign last_bit = (dcnt_q == ((ld == 3'h4) ? 2'h1 : 2'h3));

	// Frame control: kind, instruction skip, refusal and clock index
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_q <= MFR_CMD_NONE;
			skip_q <= 1'b0;
			ign_q <= 1'b0;
			k_q <= 6'h00;
		end else if (cs_hi) begin
			k_q <= 6'h00;
			ign_q <= 1'b0;
		end else if (start) begin
			// A continuous frame opens straight with the address
			cmd_q <= cont_q;
			skip_q <= (cont_q != MFR_CMD_NONE);
			ign_q <= (cont_q != MFR_CMD_NONE) && refuse(cont_q, WRITE_CYCLE_BUSY, QUAD_LINES_ENABLE_BIT);
			k_q <= 6'h00;
		end else if (rise && !ign_q && ph != MFR_PH_DATA) begin
			k_q <= k_q + 6'h01;
			if (ph == MFR_PH_INS && k_q == 6'h07) begin
				cmd_q <= op_cmd;
				// Unknown code, quad kind without enable, or write cycle running
				ign_q <= refuse(op_cmd, WRITE_CYCLE_BUSY, QUAD_LINES_ENABLE_BIT);
			end
		end
	end

	// Instruction bits arrive on line zero only
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			ins_q <= 7'h00;
		else if (rise && !cs_hi && ph == MFR_PH_INS)
			ins_q <= {ins_q[5:0], filt_q[0]};
	end

	// Address capture, then one step per byte sent
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			addr_q <= 24'h00_0000;
		else if (rise && act && ph == MFR_PH_ADDR)
			addr_q <= (addr_q << la) | {20'h0_0000, bits};
		else if (byte_start)
			addr_q <= addr_q + 24'h00_0001;
	end

	// Mode byte; only its upper nibble decides the next frame
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			mode_q <= 8'h00;
		else if (rise && act && ph == MFR_PH_MODE)
			mode_q <= mode_nx;
	end

	// Continuous read state, decided at the last mode clock
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			cont_q <= MFR_CMD_NONE;
		else if (rise && act && ph == MFR_PH_MODE && ph_next != MFR_PH_MODE) begin
			if (mode_nx[7:4] == `MFR_CONT_NIBBLE)
				cont_q <= cmd_q;
			else
				cont_q <= MFR_CMD_NONE;
		end
	end

	// Line enables: on from the first data fall until deselect
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			io_oe_q <= 4'h0;
		else if (cs_hi)
			io_oe_q <= 4'h0;
		else if (fall && act && ph == MFR_PH_DATA)
			io_oe_q <= mfr_oe(ld);
	end

	// Bit position inside the byte on the lines
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			dcnt_q <= 2'h0;
		else if (cs_hi)
			dcnt_q <= 2'h0;
		else if (fall && act && ph == MFR_PH_DATA)
			dcnt_q <= last_bit ? 2'h0 : dcnt_q + 2'h1;
	end

	// Data out on falling clocks; first byte fetched at its first bit
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			io_o_q <= 4'hF;
			sh_q <= 8'h00;
		end else if (fall && act && ph == MFR_PH_DATA) begin
			// The host has let go of the lines by now
			if (dcnt_q == 2'h0) begin
				io_o_q <= mfr_put(MEM_RDATA, ld);
				sh_q <= MEM_RDATA << ld;
			end else begin
				io_o_q <= mfr_put(sh_q, ld);
				sh_q <= sh_q << ld;
			end
		end
	end

	// Port drive from flops
	assign MEM_ADDR = addr_q;
	assign CONT_CMD = cont_q;
	assign LINK.d_io_o = io_o_q;
	assign LINK.d_io_oe = io_oe_q;
endmodule // mfr_flash_dev

// file: testbench/mfr_props.sv
// Purpose: Link checks between the host and device ends.
// Assumes: One SYS_CLK domain; host HALF of at least 10.
// Notes:   Watches the interface signals only.
`timescale 1ns/1ps
module mfr_props (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Link signals
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] h_io_o,
	input wire logic [3:0] h_io_oe,
	input wire logic [3:0] d_io_o,
	input wire logic [3:0] d_io_oe
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// Line ownership and data timing
	a_no_line_clash: assert property ((d_io_oe & h_io_oe) == 4'h0)
		else $error("both ends drive one line");
	a_oe_start_low: assert property ($rose(|d_io_oe) |-> !sck && !cs_n)
		else $error("device began driving outside a low clock");
	a_dev_bits_fall: assert property ($changed(d_io_o) |-> !sck)
		else $error("device bits moved while clock high");
	a_host_bits_fall: assert property ($changed(h_io_o) |-> !sck)
		else $error("host bits moved while clock high");
	a_oe_width_shape: assert property (d_io_oe inside {4'h0, 4'h3, 4'hF})
		else $error("device drives an odd set of lines");
	a_dev_release: assert property ($rose(cs_n) |-> ##[1:8] (d_io_oe == 4'h0))
		else $error("device kept lines after deselect");
	// Serial clock shape
	a_sck_high_time: assert property ($rose(sck) |-> sck [*8])
		else $error("serial clock high too short");
	a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("serial clock runs outside a frame");
	// Main scenarios
	c_quad_data: cover property ($rose(d_io_oe == 4'hF));
	c_dual_data: cover property ($rose(d_io_oe == 4'h3));
	c_skip_frame: cover property ($fell(cs_n) ##[1:4] (h_io_oe == 4'hF));
endmodule // mfr_props

// file: testbench/mfr_bench.sv
// Purpose: Host and device joined, driven over Wishbone.
// Assumes: Array byte at address a is a[7:0]^a[15:8]^3C.
// Notes:   Every frame reads four bytes from consecutive addresses.
`timescale 1ns/1ps
module mfr_bench;
	import mfr_pkg::*;
	logic SYS_CLK, RST_N, cyc, stb, we, ack, dev_quad_en, busy;
	logic [7:0] adr, mem_rdata;
	logic [31:0] wdat, rdat, q;
	logic [23:0] mem_addr;
	mfr_cmd_e cont;
	int num_errors = 0;
	int comparisons = 0;
	mfr_link_if link();
	mfr_host #(.HALF(10)) i_mfr_host (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
		.LINK(link));
	mfr_flash_dev i_mfr_flash_dev (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LINK(link),
		.QUAD_LINES_ENABLE_BIT(dev_quad_en), .WRITE_CYCLE_BUSY(busy), .MEM_ADDR(mem_addr),
		.MEM_RDATA(mem_rdata), .CONT_CMD(cont));
	mfr_props i_mfr_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .sck(link.sck), .cs_n(link.cs_n),
		.h_io_o(link.h_io_o), .h_io_oe(link.h_io_oe), .d_io_o(link.d_io_o), .d_io_oe(link.d_io_oe));
	// Array contents
	assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C;
	initial begin
		SYS_CLK = 0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end
	// Compare and verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Classic Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge SYS_CLK); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	// One frame of kind k; waits for done or refusal, then fetches the data word
	task automatic run(input logic [2:0] k, input logic [23:0] a, input logic [7:0] m, input logic quad_en);
		int n;
		wb(1, 8'h04, {8'h00, a});
		wb(1, 8'h08, {24'h00_0000, m});
		// GO in bit 9, quad enable in bit 8, four bytes in bits 5:4
		wb(1, 8'h00, {22'h00_0000, 1'b1, quad_en, 2'h0, 2'h3, 1'b0, k});
		n = 0;
		do begin
			wb(0, 8'h0C, 32'h0000_0000);
			n++;
		end while (q[1] !== 1'b1 && q[3] !== 1'b1 && n < 2000);
		if (n >= 2000) chk("done", 32'h0000_0002, q);
		wb(0, 8'h10, 32'h0000_0000);
	endtask
	function automatic logic [31:0] expw(input logic [2:0] k, input logic [23:0] a);
		logic [23:0] b;
		logic [31:0] r;
		b = (k == 3'h4) ? {a[23:1], 1'b0} : (k == 3'h5) ? {a[23:4], 4'h0} : a;
		for (int i = 0; i < 4; i++) r[31-8*i -: 8] = (b[7:0] + 8'(i)) ^ b[15:8] ^ 8'h3C;
		return r;
	endfunction
	// Watchdog
	initial begin
		repeat (80000) @(posedge SYS_CLK);
		num_errors++;
		results();
	end
	// Main sequence
	initial begin
		RST_N = 0;
		{cyc, stb, we, adr, wdat} = '0;
		dev_quad_en = 1;
		busy = 0;
		repeat (20) @(posedge SYS_CLK);
		RST_N <= 1;
		repeat (8) @(posedge SYS_CLK);
		for (int k = 1; k <= 5; k++) begin
			run(3'(k), 24'h12_3457, 8'h05, 1);
			chk("data", expw(3'(k), 24'h12_3457), q);
		end
		run(3'h1, 24'h00_00F4, 8'hA0, 1);
		chk("quad out even", expw(3'h1, 24'h00_00F4), q);
		chk("quad out cont", 32'h0000_0000, {29'h0, cont});
		for (int k = 2; k <= 5; k++) begin
			run(3'(k), 24'h00_20F0, 8'hA3, 1);
			chk("cont kind", 32'(k), {29'h0, cont});
			run(3'(k), 24'h00_31F9, 8'h5A, 1);
			chk("skip data", expw(3'(k), 24'h00_31F9), q);
			chk("cont left", 32'h0000_0000, {29'h0, cont});
		end
		dev_quad_en <= 0;
		run(3'h3, 24'h00_0040, 8'h00, 1);
		chk("no quad enable", 32'hFFFF_FFFF, q);
		run(3'h1, 24'h00_0040, 8'h00, 1);
		chk("quad out refused", 32'hFFFF_FFFF, q);
		run(3'h2, 24'h00_0040, 8'h00, 1);
		chk("dual no enable", expw(3'h2, 24'h00_0040), q);
		dev_quad_en <= 1;
		busy <= 1;
		run(3'h2, 24'h00_0080, 8'h00, 1);
		chk("busy ignored", 32'hFFFF_FFFF, q);
		busy <= 0;
		run(3'h1, 24'h00_0010, 8'h00, 0);
		wb(0, 8'h0C, 32'h0000_0000);
		chk("host refused", 32'h0000_0008, q & 32'h0000_0008);
		wb(0, 8'h14, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		results();
	end
endmodule // mfr_bench
